// [decode_pkg.sv]
// Shared constants and types for the instruction decode and timing block
package decode_pkg;
   localparam int WORD_W        = 16;
   localparam int FILE_W        = 8;
   localparam int LONG_FILE_W   = 12;
   localparam int TARGET_W      = 20;
   localparam int TABLE_PTR_W   = 21;
   localparam int OSC_PER_CYCLE = 4;
   localparam logic [1:0] PHASE_RESET = 2'h0;
   localparam logic [1:0] PHASE_LAST  = 2'h3;
   localparam logic [3:0] SECOND_WORD_NIBBLE = 4'hf;
   localparam logic [15:0] NOP_WORD = 16'h0000;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   // Flag bit positions
   localparam int FLAG_CARRY  = 0;
   localparam int FLAG_NIBBLE = 1;
   localparam int FLAG_ZERO   = 2;
   localparam int FLAG_OVF    = 3;
   localparam int FLAG_NEG    = 4;

   typedef enum logic [1:0]
   {
      CLASS_BYTE    = 2'b00,
      CLASS_BIT     = 2'b01,
      CLASS_LITERAL = 2'b10,
      CLASS_CONTROL = 2'b11
   } op_class_t;

   typedef enum logic [1:0]
   {
      TBL_KEEP     = 2'b00,
      TBL_POST_INC = 2'b01,
      TBL_POST_DEC = 2'b10,
      TBL_PRE_INC  = 2'b11
   } table_mode_t;

   typedef enum logic [1:0]
   {
      SEQ_FIRST   = 2'b00,
      SEQ_SECOND  = 2'b01,
      SEQ_FLUSH   = 2'b10
   } seq_state_t;
endpackage

// [field_extract.sv]
// Combinational split of one instruction word into class and operand fields
`timescale 1ns/1ps
`default_nettype none
module field_extract
(
   input  wire logic [15:0]              word,          // Fetched instruction word
   output decode_pkg::op_class_t         op_class,      // Operation class
   output logic                          dest_file,     // 1 result to file, 0 to accumulator
   output logic                          access_banked, // 1 bank select applies
   output logic [2:0]                    bit_number,    // Bit within file register
   output logic [7:0]                    file_addr,     // Short file address
   output logic [11:0]                   long_addr,     // Twelve-bit file address
   output logic [7:0]                    literal8,      // Eight-bit literal
   output logic [11:0]                   literal12,     // Twelve-bit literal
   output decode_pkg::table_mode_t       table_mode,    // Table pointer mode
   output logic                          fast_select,   // Shadow register select
   output logic                          is_second_word,// Upper nibble all ones
   output logic                          is_two_word,   // First word of a two-word op
   output logic                          is_table_op,   // Table read or write
   output logic                          is_cond_branch,// Conditional relative branch
   output logic                          is_uncond_jump,// Relative jump or call
   output logic                          is_return,     // Return forms
   output logic                          is_move_ff,    // Register to register move
   output logic signed [10:0]            rel_offset     // Sign-extended branch offset
);
   wire [3:0] top = word[15:12];
   wire       long_rel = (top == 4'hd);
   wire       short_rel = (word[15:11] == 5'b11100);
   wire       op_zero = (word[15:8] == 8'h00);
   wire       is_call = (word[15:9] == 7'b1110110);
   wire       fast_ret = op_zero && (word[7:2] == 6'b000100);

   // Bit ops live at 0x7..0xb, literal-class at 0x08..0x0f, return with literal is control
   assign op_class = (top >= 4'h7 && top <= 4'hb) ? decode_pkg::CLASS_BIT :         // see [RULE_03]
                     (top == 4'hc) ? decode_pkg::CLASS_BYTE :
                     (top == 4'hd || top == 4'he || top == 4'hf) ? decode_pkg::CLASS_CONTROL :
                     (word[15:8] == 8'h0c) ? decode_pkg::CLASS_CONTROL :
                     (word[15:11] == 5'b00001) ? decode_pkg::CLASS_LITERAL :
                     (op_zero) ? decode_pkg::CLASS_CONTROL :
                     decode_pkg::CLASS_BYTE;
   assign dest_file      = word[9];                                 // see [RULE_09]
   assign access_banked  = word[8];                                 // see [RULE_10]
   assign bit_number     = word[11:9];                              // see [RULE_11]
   assign file_addr      = word[7:0];                               // see [RULE_12]
   assign long_addr      = word[11:0];                              // see [RULE_13]
   assign literal8       = word[7:0];                               // see [RULE_14]
   assign literal12      = word[11:0];
   assign table_mode     = decode_pkg::table_mode_t'(word[1:0]);    // see [RULE_16]
   // Call keeps its fast bit beside the opcode, the returns keep it in bit zero
   assign fast_select    = is_call ? word[8] : (fast_ret && word[0]); // see [RULE_18]
   assign is_second_word = (top == decode_pkg::SECOND_WORD_NIBBLE); // see [RULE_04]
   assign is_move_ff     = (top == 4'hc);
   assign is_two_word    = is_move_ff || (word[15:9] == 7'b1110110)
                           || (word[15:8] == 8'hef);                // see [RULE_01]
   assign is_table_op    = op_zero && (word[7:3] == 5'b00001);
   assign is_cond_branch = short_rel;
   assign is_uncond_jump = long_rel;
   assign is_return      = (op_zero && word[7:1] == 7'b0001000) || (op_zero && word[7:1] == 7'b0001001)
                           || (word[15:8] == 8'h0c);
   // Relative offsets are two's complement
   assign rel_offset     = long_rel ? $signed(word[10:0])
                                    : $signed({{3{word[7]}}, word[7:0]}); // see [RULE_19]
endmodule
`default_nettype wire

// [instr_decode.sv]
// Instruction decode, operand routing and cycle timing for an 8-bit core
// Contract
// [RULE_01] Single-word instructions, three take two words
// [RULE_02] Word splits into opcode and operand fields
// [RULE_03] Four classes: byte, bit, literal, control
// [RULE_04] Lone second word executes as no-operation
// [RULE_05] One cycle; two when skipping or jumping
// [RULE_06] Two-word instructions take two cycles
// [RULE_07] Instruction cycle equals four oscillator periods
// [RULE_08] Taken two-word branch takes three cycles
// [RULE_09] Destination bit: accumulator or file register
// [RULE_10] Access bit: access window or bank
// [RULE_11] Three-bit field picks bit zero..seven
// [RULE_12] Short file address is eight bits
// [RULE_13] Move carries two twelve-bit addresses
// [RULE_14] Literals are eight, twelve or twenty bits
// [RULE_15] File field may pick indirect pointer
// [RULE_16] Four table pointer modes
// [RULE_17] Table pointer 21 bits, latch 8 bits; neither register is modelled here, only the TABLE_PTR_W width constant
// [RULE_18] Fast bit saves or restores shadows
// [RULE_19] Offset relative signed, else absolute
// [RULE_20] Don't-care bits should be zero
// [RULE_21] Five arithmetic status flags kept
// [RULE_22] Absolute target joins low byte, upper twelve
// [RULE_23] Prefetched word discarded on taken change
`timescale 1ns/1ps
`default_nettype none
module instr_decode
#(
   parameter int OSC_PER_CYCLE = decode_pkg::OSC_PER_CYCLE
)
(
   input  wire logic                      clk,              // Oscillator clock
   input  wire logic                      reset,            // Asynchronous reset, high
   input  wire logic [15:0]               fetch_word,       // Word from program memory
   input  wire logic                      condition_true,   // Skip or branch test outcome
   input  wire logic [4:0]                flag_update_mask, // Flags the executing op writes
   input  wire logic [4:0]                flag_values,      // New flag values from the ALU
   output logic                           cycle_strobe,     // Last oscillator period of cycle
   output logic [1:0]                     osc_phase,        // Oscillator period within cycle
   output logic                           fetch_advance,    // Take next program word
   output decode_pkg::op_class_t          exec_class,       // Class of executing op
   output logic                           exec_nop,         // Executing as no-operation
   output logic                           to_accumulator,   // Result goes to working_accumulator
   output logic                           use_bank,         // ram_bank_select applies
   output logic [2:0]                     exec_bit,         // Bit number
   output logic [7:0]                     exec_file,        // Short file address
   output logic [11:0]                    move_src,         // Move source address
   output logic [11:0]                    move_dst,         // Move destination address
   output logic [7:0]                     exec_literal8,    // Eight-bit literal
   output logic [11:0]                    exec_literal12,   // Twelve-bit literal
   output logic [19:0]                    exec_target,      // Absolute twenty-bit target
   output logic [1:0]                     pointer_select,   // indirect_pointer_register pick
   output decode_pkg::table_mode_t        exec_table_mode,  // program_table_pointer mode
   output logic                           shadow_use,       // Fast shadow save or restore
   output logic signed [10:0]             exec_offset,      // Relative branch offset
   output logic [4:0]                     status_flags,     // C, nibble carry, Z, OV, N
   output logic [1:0]                     cycles_taken      // Cycles used by last instruction
);
   localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);

   decode_pkg::op_class_t     f_class;
   decode_pkg::table_mode_t   f_mode;
   decode_pkg::seq_state_t    state;
   decode_pkg::seq_state_t    next_state;
   logic        f_dest;
   logic        f_bank;
   logic [2:0]  f_bit;
   logic [7:0]  f_file;
   logic [11:0] f_long;
   logic [7:0]  f_lit8;
   logic [11:0] f_lit12;
   logic        f_fast;
   logic        f_second;
   logic        f_two;
   logic        f_table;
   logic        f_cond;
   logic        f_jump;
   logic        f_ret;
   logic        f_move;
   logic signed [10:0] f_off;
   logic [15:0] first_word;
   logic        first_cond;
   logic [1:0]  cycle_count;

   field_extract u_fields
   (
      .word           (fetch_word),
      .op_class       (f_class),
      .dest_file      (f_dest),
      .access_banked  (f_bank),
      .bit_number     (f_bit),
      .file_addr      (f_file),
      .long_addr      (f_long),
      .literal8       (f_lit8),
      .literal12      (f_lit12),
      .table_mode     (f_mode),
      .fast_select    (f_fast),
      .is_second_word (f_second),
      .is_two_word    (f_two),
      .is_table_op    (f_table),
      .is_cond_branch (f_cond),
      .is_uncond_jump (f_jump),
      .is_return      (f_ret),
      .is_move_ff     (f_move),
      .rel_offset     (f_off)
   );

   // Cycle phase: four oscillator periods per instruction cycle
   always_ff @(posedge clk or posedge reset)
      if (reset)
         osc_phase <= decode_pkg::PHASE_RESET;
      else
         osc_phase <= (osc_phase == PHASE_LAST) ? decode_pkg::PHASE_RESET
                                                : 2'(osc_phase + 2'h1);     // see [RULE_07]

   assign cycle_strobe  = (osc_phase == PHASE_LAST);
   assign fetch_advance = cycle_strobe;

   // Decoded events valid in the first word state
   wire first_two   = (state == decode_pkg::SEQ_FIRST) && f_two;
   wire taken_pc    = (state == decode_pkg::SEQ_FIRST) && !f_second
                      && ((f_cond && condition_true) || f_jump || f_ret);
   wire skip_taken  = (state == decode_pkg::SEQ_FIRST) && !f_second && !f_cond && !f_jump
                      && condition_true;
   wire lone_second = (state == decode_pkg::SEQ_FIRST) && f_second;         // see [RULE_04]

   always_comb
   begin
      next_state = state;
      case (state)
         decode_pkg::SEQ_FIRST:
            if (first_two)
               next_state = decode_pkg::SEQ_SECOND;                         // see [RULE_06]
            else if (taken_pc || skip_taken)
               next_state = decode_pkg::SEQ_FLUSH;                          // see [RULE_05]
         decode_pkg::SEQ_SECOND:
            // Absolute jump and call always discard the prefetch afterwards
            if (first_cond)
               next_state = decode_pkg::SEQ_FLUSH;                          // see [RULE_08]
            else
               next_state = decode_pkg::SEQ_FIRST;
         decode_pkg::SEQ_FLUSH:
            next_state = decode_pkg::SEQ_FIRST;                             // see [RULE_23]
         default:
            next_state = decode_pkg::SEQ_FIRST;
      endcase
   end

   always_ff @(posedge clk or posedge reset)
      if (reset)
         state <= decode_pkg::SEQ_FIRST;
      else if (cycle_strobe)
         state <= next_state;

   // First word held for the second cycle of a two-word op
   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         first_word <= decode_pkg::NOP_WORD;
         first_cond <= 1'b0;
      end
      else if (cycle_strobe && first_two)
      begin
         first_word <= fetch_word;
         first_cond <= !f_move;
      end

   // Cycle count of the instruction in flight
   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         cycle_count  <= 2'h0;
         cycles_taken <= 2'h0;
      end
      else if (cycle_strobe)
      begin
         cycle_count <= (next_state == decode_pkg::SEQ_FIRST) ? 2'h0 : 2'(cycle_count + 2'h1);
         if (next_state == decode_pkg::SEQ_FIRST)
            cycles_taken <= 2'(cycle_count + 2'h1);
      end

   // Operand fields registered at the end of first-word and second-word cycles, held through flush cycles
   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         exec_class      <= decode_pkg::CLASS_CONTROL;
         exec_nop        <= 1'b1;
         to_accumulator  <= 1'b0;
         use_bank        <= 1'b0;
         exec_bit        <= 3'h0;
         exec_file       <= 8'h00;
         move_src        <= 12'h000;
         move_dst        <= 12'h000;
         exec_literal8   <= 8'h00;
         exec_literal12  <= 12'h000;
         exec_target     <= 20'h00000;
         pointer_select  <= 2'h0;
         exec_table_mode <= decode_pkg::TBL_KEEP;
         shadow_use      <= 1'b0;
         exec_offset     <= 11'sh000;
      end
      else if (cycle_strobe)
      begin
         exec_nop <= (state == decode_pkg::SEQ_FLUSH) || lone_second;       // see [RULE_04]
         if (state == decode_pkg::SEQ_FIRST)
         begin
            exec_class      <= f_class;                                     // see [RULE_02]
            to_accumulator  <= !f_dest;                                     // see [RULE_09]
            use_bank        <= f_bank;                                      // see [RULE_10]
            exec_bit        <= f_bit;                                       // see [RULE_11]
            exec_file       <= f_file;                                      // see [RULE_12]
            move_src        <= f_long;                                      // see [RULE_13]
            exec_literal8   <= f_lit8;                                      // see [RULE_14]
            exec_literal12  <= f_lit12;
            pointer_select  <= fetch_word[5:4];                             // see [RULE_15]
            exec_table_mode <= f_table ? f_mode : decode_pkg::TBL_KEEP;     // see [RULE_16]
            shadow_use      <= f_fast;                                      // see [RULE_18]
            exec_offset     <= f_off;                                       // see [RULE_19]
         end
         else if (state == decode_pkg::SEQ_SECOND)
         begin
            move_dst    <= f_long;                                          // see [RULE_13]
            exec_target <= {fetch_word[11:0], first_word[7:0]};             // see [RULE_22]
         end
      end

   // Five status flags written per the executing operation
   always_ff @(posedge clk or posedge reset)
      if (reset)
         status_flags <= decode_pkg::FLAGS_RESET;
      else if (cycle_strobe && !exec_nop)
         status_flags <= (status_flags & ~flag_update_mask)
                         | (flag_values & flag_update_mask);                // see [RULE_21]

   // Cycle figures of the sequencer
   sequence s_two_word_start;
      cycle_strobe && state == decode_pkg::SEQ_FIRST && f_two;
   endsequence
   sequence s_lands_second;
      (!cycle_strobe)[*3] ##1 state == decode_pkg::SEQ_SECOND;
   endsequence

   AST_PHASE_WRAP: assert property (@(posedge clk) disable iff (reset)   // see [RULE_07]
      cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe)
      else $error("instruction cycle not four periods");
   AST_TWO_WORD: assert property (@(posedge clk) disable iff (reset)     // see [RULE_06]
      s_two_word_start |=> s_lands_second)
      else $error("two-word op did not enter second word");
   AST_FLUSH_NOP: assert property (@(posedge clk) disable iff (reset)    // see [RULE_23]
      cycle_strobe && state == decode_pkg::SEQ_FLUSH |=> exec_nop)
      else $error("flushed cycle not a no-operation");
   AST_LONE_SECOND: assert property (@(posedge clk) disable iff (reset)  // see [RULE_04]
      cycle_strobe && state == decode_pkg::SEQ_FIRST && f_second |=> exec_nop)
      else $error("lone second word executed");
   AST_DEST: assert property (@(posedge clk) disable iff (reset)         // see [RULE_09]
      cycle_strobe && state == decode_pkg::SEQ_FIRST |=> to_accumulator == !$past(fetch_word[9]))
      else $error("destination routing wrong");
   AST_BANK: assert property (@(posedge clk) disable iff (reset)         // see [RULE_10]
      cycle_strobe && state == decode_pkg::SEQ_FIRST |=> use_bank == $past(fetch_word[8]))
      else $error("access select wrong");
   AST_SINGLE: assert property (@(posedge clk) disable iff (reset)       // see [RULE_05]
      cycle_strobe && state == decode_pkg::SEQ_FIRST && !f_two && !taken_pc && !skip_taken
      |=> state == decode_pkg::SEQ_FIRST)
      else $error("plain single-word op took extra cycle");
   AST_THREE: assert property (@(posedge clk) disable iff (reset)        // see [RULE_08]
      cycle_strobe && state == decode_pkg::SEQ_SECOND && first_cond
      |=> state == decode_pkg::SEQ_FLUSH)
      else $error("taken two-word branch not three cycles");
   AST_TARGET: assert property (@(posedge clk) disable iff (reset)       // see [RULE_22]
      cycle_strobe && state == decode_pkg::SEQ_SECOND
      |=> exec_target[7:0] == first_word[7:0])
      else $error("absolute target low byte wrong");
endmodule
`default_nettype wire

// [prog_memory.sv]
// Program memory model that hands instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module prog_memory
(
   input  wire logic        clk,           // Oscillator clock
   input  wire logic        reset,         // Asynchronous reset, high
   input  wire logic        fetch_advance, // Step to the next word
   output logic [15:0]      fetch_word,    // Word at the current index
   output logic [5:0]       word_index     // Current word index
);
   logic [15:0] store [0:63];

   // Stored words keep every don't-care bit at zero
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         word_index <= 6'h00;
      else if (fetch_advance)
         word_index <= word_index + 6'h01;
   end

   assign fetch_word = store[word_index];
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking testbench for the instruction decode and timing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [15:0] PROG [0:21] = '{16'h27a5, 16'h8b3c, 16'h0e7f, 16'h5001, 16'hc123,
      16'hf456, 16'hef12, 16'hf345, 16'h27ff, 16'hf000, 16'ha1c0, 16'h0e55, 16'hd7ff,
      16'h0e11, 16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'hed04, 16'hf7a9, 16'h27ff, 16'h0000};
   logic                        clk, reset, condition_true, cycle_strobe, fetch_advance;
   logic                        exec_nop, to_accumulator, use_bank, shadow_use;
   logic [15:0]                 fetch_word;
   logic [4:0]                  flag_update_mask, flag_values, status_flags;
   logic [1:0]                  osc_phase, pointer_select, cycles_taken;
   logic [2:0]                  exec_bit;
   logic [7:0]                  exec_file, exec_literal8;
   logic [11:0]                 move_src, move_dst, exec_literal12;
   logic [19:0]                 exec_target;
   logic signed [10:0]          exec_offset;
   decode_pkg::op_class_t       exec_class;
   decode_pkg::table_mode_t     exec_table_mode;
   int                          mismatches = 0;
   int                          samples_checked = 0;

   prog_memory mem (.clk(clk), .reset(reset), .fetch_advance(fetch_advance),
                    .fetch_word(fetch_word), .word_index());
   instr_decode uut (.clk(clk), .reset(reset), .fetch_word(fetch_word),
      .condition_true(condition_true), .flag_update_mask(flag_update_mask),
      .flag_values(flag_values), .cycle_strobe(cycle_strobe), .osc_phase(osc_phase),
      .fetch_advance(fetch_advance), .exec_class(exec_class), .exec_nop(exec_nop),
      .to_accumulator(to_accumulator), .use_bank(use_bank), .exec_bit(exec_bit),
      .exec_file(exec_file), .move_src(move_src), .move_dst(move_dst),
      .exec_literal8(exec_literal8), .exec_literal12(exec_literal12),
      .exec_target(exec_target), .pointer_select(pointer_select),
      .exec_table_mode(exec_table_mode), .shadow_use(shadow_use), .exec_offset(exec_offset),
      .status_flags(status_flags), .cycles_taken(cycles_taken));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic compare(input logic [19:0] got, input logic [19:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits for the falling edge inside the strobe that takes word k
   task automatic at(input int k);
      int n;
      n = 0;
      @(negedge clk);
      while (!(cycle_strobe === 1'b1 && mem.word_index === 6'(k)) && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 400)
      begin
         mismatches++;
         end_of_test();
      end
      condition_true = 1'b0;
      flag_update_mask = 5'h00;
      flag_values = 5'h00;
   endtask

   task automatic check_reset();
      compare(exec_nop, 1'b1);
      compare(exec_class, decode_pkg::CLASS_CONTROL);
      compare(status_flags, decode_pkg::FLAGS_RESET);
   endtask

   // Flags are offered while an op executes and land at the rising edge that ends that same strobe
   task automatic byte_bit_literal();
      at(0);
      at(1);
      compare(exec_class, decode_pkg::CLASS_BYTE);
      compare(to_accumulator, 1'b0);
      compare(use_bank, 1'b1);
      compare(exec_file, 8'ha5);
      compare(pointer_select, 2'h2);
      compare(cycles_taken, 2'h1);
      flag_update_mask = 5'h1f;
      flag_values = 5'h15;
      at(2);
      compare(status_flags, 5'h15);
      compare(exec_class, decode_pkg::CLASS_BIT);
      compare(exec_bit, 3'h5);
      compare(exec_file, 8'h3c);
      at(3);
      compare(exec_class, decode_pkg::CLASS_LITERAL);
      compare(exec_literal8, 8'h7f);
      at(4);
      compare(to_accumulator, 1'b1);
      compare(use_bank, 1'b0);
      compare(exec_file, 8'h01);
   endtask

   // Move then absolute jump; the flushed word also offers flags that must be dropped
   task automatic move_and_jump();
      at(5);
      compare(move_src, 12'h123);
      at(6);
      compare(move_dst, 12'h456);
      compare(cycles_taken, 2'h2);
      at(8);
      compare(exec_target, 20'h34512);
      at(9);
      compare(exec_nop, 1'b1);
      compare(cycles_taken, 2'h3);
      flag_update_mask = 5'h1f;
      flag_values = 5'h0a;
   endtask

   task automatic lone_skip_branch();
      at(10);
      compare(status_flags, 5'h15);
      compare(exec_nop, 1'b1);
      condition_true = 1'b1;
      at(11);
      compare(exec_class, decode_pkg::CLASS_BIT);
      compare(exec_nop, 1'b0);
      at(12);
      compare(exec_nop, 1'b1);
      compare(cycles_taken, 2'h2);
      at(13);
      compare(exec_class, decode_pkg::CLASS_CONTROL);
      compare(unsigned'(exec_offset), 20'h007ff);
      compare(exec_literal12, 12'h7ff);
      at(14);
      compare(exec_nop, 1'b1);
      compare(cycles_taken, 2'h2);
   endtask

   // Call carries its fast bit beside the opcode while bit zero stays clear
   task automatic table_and_call();
      for (int m = 0; m < 4; m++)
      begin
         at(15 + m);
         compare(exec_table_mode, 20'(m));
      end
      at(19);
      compare(shadow_use, 1'b1);
      at(20);
      compare(exec_target, 20'h7a904);
      at(21);
      compare(exec_nop, 1'b1);
      compare(cycles_taken, 2'h3);
   endtask

   task automatic check_timing();
      int n;
      n = 0;
      compare(osc_phase, decode_pkg::PHASE_LAST);
      compare(fetch_advance, 1'b1);
      @(negedge clk);
      n++;
      while (cycle_strobe !== 1'b1 && n < 9)
      begin
         @(negedge clk);
         n++;
      end
      compare(20'(n), 20'h4);
   endtask

   initial
   begin
      reset = 1'b1;
      condition_true = 1'b0;
      flag_update_mask = 5'h00;
      flag_values = 5'h00;
      for (int i = 0; i < 64; i++)
         mem.store[i] = (i < 22) ? PROG[i] : decode_pkg::NOP_WORD;
      repeat (4) @(negedge clk);
      check_reset();
      reset = 1'b0;
      byte_bit_literal();
      move_and_jump();
      lone_skip_branch();
      table_and_call();
      check_timing();
      end_of_test();
   end
endmodule
`default_nettype wire
